/* File: sbc_pkg.sv */
// Shared constants and types for the strap and boot configuration loader.
// Assumes a 32-bit APB slave with one aligned word per register.
package sbc_pkg;

    // ****************************************************************
    // Register map and control fields
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STRAP = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_EE_ADDR = 8'h0C;
    localparam logic [7:0] OFS_EE_DATA = 8'h10;
    localparam logic [7:0] OFS_EE_PTR = 8'h14;
    localparam logic [7:0] OFS_BEACON = 8'h18;
    localparam logic [7:0] OFS_SUPPLY = 8'h1C;
    localparam int CTL_SOFT_RST = 0;
    localparam int CTL_CPU_RUN = 1;
    localparam int CTL_EE_RESTART = 2;
    localparam int CTL_EE_MANUAL = 3;
    localparam int CTL_DOZE = 4;
    localparam int SUP_SYNTH = 0;
    localparam int SUP_XOSC = 1;
    localparam logic [15:0] BEACON_RST = 16'h0064;
    localparam logic [1:0] SUPPLY_RST = 2'h3;

    // ****************************************************************
    // Strap pin positions and capture timing
    // ****************************************************************
    localparam int STR_W = 10;
    localparam int STR_FLASH_W = 9;
    localparam int STR_CS_HI = 8;
    localparam int STR_CS_LO = 7;
    localparam int STR_HOST_HI = 6;
    localparam int STR_HOST_LO = 5;
    localparam int STR_PAD = 4;
    localparam int STR_ENDIAN = 3;
    localparam int STR_FW_SRC = 2;
    localparam int STR_AUTO = 0;
    localparam logic [1:0] CAP_WAIT = 2'h3;

    // ****************************************************************
    // Serial configuration memory burst layout
    // ****************************************************************
    localparam int EE_AW = 8;
    localparam int EE_DW = 16;
    localparam logic [7:0] BURST_LAST = 8'h07;
    localparam logic [7:0] PTR_WORD = 8'h03;

    typedef enum logic [1:0] {
        SBC_CS_ZERO = 2'b00,
        SBC_CS_ONE = 2'b01,
        SBC_CS_TWO = 2'b10,
        SBC_CS_NONE = 2'b11
    } sbc_cs_t;

    typedef enum logic [1:0] {
        SBC_HOST_CARDBUS = 2'b00,
        SBC_HOST_PCI = 2'b01,
        SBC_HOST_SLAVE = 2'b10,
        SBC_HOST_PCI_CTRL = 2'b11
    } sbc_host_t;

    typedef struct packed {
        logic flash_16bit;
        sbc_cs_t flash_cs;
        sbc_host_t host_mode;
        logic pad_pci;
        logic big_endian;
        logic fw_from_flash;
        logic auto_ee_read;
        logic card_mode;
    } sbc_strap_t;

    typedef enum logic [1:0] {
        SBC_ST_IDLE = 2'b00,
        SBC_ST_REQ = 2'b01,
        SBC_ST_REL = 2'b10
    } sbc_ee_st_t;

endpackage

/* File: sbc_strap_boot_loader.sv */
// Strap capture, boot-time configuration memory reads and doze supplies.
// Assumes strap, acknowledge, data and sleep clock pins are asynchronous
// and that software reaches the registers over APB on i_clk.
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ns

// Behaviour
// - Sample strap pins 9:2 and 0 at reset.
// - Store sampled straps in configuration registers.
// - Strap 9 selects 8-bit or 16-bit flash.
// - Straps 8:7 pick flash select or none.
// - Straps 6:5 choose host interface mode.
// - Strap 4 sets host pad configuration.
// - Strap 3 sets processor byte order.
// - Strap 2 picks host download or flash.
// - Strap 0 enables automatic memory read.
// - Card mode pin refines slave mode.
// - Start burst read after strap capture.
// - Firmware restarts burst; pointer word captured.
// - Firmware then reads tables manually, boot ends.
// - Doze keeps sleep timer, wakes each beacon.
// - Doze drives regulator enables off, line ten.
// - Supplies off entering doze, on leaving.
module sbc_strap_boot_loader (
    // Clock, reset and freeze.
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    // APB slave.
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [sbc_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Strap pins.
    input wire logic [sbc_pkg::STR_W-1:0] i_strap_data_bus,
    input wire logic i_card_mode_select,
    // Serial configuration memory word port, four-phase handshake.
    output logic o_ee_req,
    output logic [sbc_pkg::EE_AW-1:0] o_ee_addr,
    input wire logic i_ee_ack,
    input wire logic [sbc_pkg::EE_DW-1:0] i_ee_data,
    // Sleep clock pin and supply controls.
    input wire logic i_sleep_clk,
    output logic o_general_purpose_line_ten,
    output logic o_crystal_osc_enable_n,
    output logic o_core_power_en,
    // Latched configuration.
    output sbc_pkg::sbc_strap_t o_cfg,
    output logic [2:0] o_flash_cs_en,
    output logic o_embedded_processor_run
);
    import sbc_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [STR_W-1:0] str_m_r, str_s_r;
    logic cms_m_r, cms_s_r, ack_m_r, ack_s_r;
    logic slp_m_r, slp_s_r, slp_d_r;
    logic [EE_DW-1:0] dat_m_r, dat_s_r;
    logic [1:0] cap_cnt_r;
    sbc_strap_t strap_r, strap_now;
    sbc_ee_st_t st_r;
    logic burst_r, first_done_r, second_done_r, boot_done_r;
    logic [7:0] word_r;
    logic [EE_AW-1:0] ee_addr_r, cur_addr_r;
    logic [EE_DW-1:0] ee_data_r, ptr_r;
    logic cpu_run_r, doze_r;
    logic [15:0] beacon_r, slp_cnt_r;
    logic [1:0] supply_off_r;
    logic [31:0] prdata_r, rd_mux;
    logic hit, wr_en, wr_ctl, soft_rst, cap_fire, cap_done;
    logic auto_go, restart_go, manual_go, slp_tick, wake;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    // Two flops per pin, three on the sleep clock; only the second stage, and the sleep clock's third, feed any logic.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            str_m_r <= '0;
            str_s_r <= '0;
            cms_m_r <= 1'b0;
            cms_s_r <= 1'b0;
            ack_m_r <= 1'b0;
            ack_s_r <= 1'b0;
            dat_m_r <= '0;
            dat_s_r <= '0;
            slp_m_r <= 1'b0;
            slp_s_r <= 1'b0;
            slp_d_r <= 1'b0;
        end else if (i_ce) begin
            str_m_r <= i_strap_data_bus;
            str_s_r <= str_m_r;
            cms_m_r <= i_card_mode_select;
            cms_s_r <= cms_m_r;
            ack_m_r <= i_ee_ack;
            ack_s_r <= ack_m_r;
            dat_m_r <= i_ee_data;
            dat_s_r <= dat_m_r;
            slp_m_r <= i_sleep_clk;
            slp_s_r <= slp_m_r;
            slp_d_r <= slp_s_r;
        end
    end

    // ****************************************************************
    // Strap decode and capture
    // ****************************************************************
    // Strap bit 1 is not a strap and is never looked at.
    always_comb begin
        strap_now.flash_16bit = str_s_r[STR_FLASH_W];
        strap_now.flash_cs = sbc_cs_t'(str_s_r[STR_CS_HI:STR_CS_LO]);
        strap_now.host_mode =
            sbc_host_t'(str_s_r[STR_HOST_HI:STR_HOST_LO]);
        strap_now.pad_pci = str_s_r[STR_PAD];
        strap_now.big_endian = str_s_r[STR_ENDIAN];
        strap_now.fw_from_flash = str_s_r[STR_FW_SRC];
        strap_now.auto_ee_read = str_s_r[STR_AUTO];
        strap_now.card_mode = cms_s_r;
    end

    // The wait lets the synchronisers fill with real pin levels first.
    assign cap_fire = (cap_cnt_r == 2'h1);
    assign cap_done = (cap_cnt_r == 2'h0);

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cap_cnt_r <= CAP_WAIT;
        end else if (i_ce) begin
            if (soft_rst) begin
                cap_cnt_r <= CAP_WAIT;
            end else if (!cap_done) begin
                cap_cnt_r <= cap_cnt_r - 2'h1;
            end
        end
    end

    // Loaded once per reset; the pins are shared and ignored afterwards.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            strap_r <= '0;
        end else if (i_ce && cap_fire) begin
            strap_r <= strap_now;
        end
    end

    assign o_cfg = strap_r;
    // One-hot flash select; the no-flash code leaves all three off.
    always_comb begin
        o_flash_cs_en = 3'h0;
        if (strap_r.flash_cs != SBC_CS_NONE) begin
            o_flash_cs_en[strap_r.flash_cs] = 1'b1;
        end
    end

    // ****************************************************************
    // APB slave
    // ****************************************************************
    // Zero wait states; unmapped offsets answer with an error.
    assign o_pready = 1'b1;
    assign wr_en = i_ce && i_psel && i_penable && i_pwrite;
    assign wr_ctl = wr_en && (i_paddr == OFS_CTRL);
    assign soft_rst = wr_ctl && i_pwdata[CTL_SOFT_RST];
    assign o_pslverr = i_psel && i_penable && !hit;
    assign o_prdata = prdata_r;

    always_comb begin
        hit = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (i_paddr)
            OFS_CTRL: rd_mux = {27'h0, doze_r, 2'h0, cpu_run_r, 1'b0};
            OFS_STRAP: rd_mux = {22'h0, strap_r};
            OFS_STATUS: rd_mux = {26'h0, boot_done_r, second_done_r,
                                  first_done_r, burst_r, st_r};
            OFS_EE_ADDR: rd_mux = {24'h0, ee_addr_r};
            OFS_EE_DATA: rd_mux = {16'h0, ee_data_r};
            OFS_EE_PTR: rd_mux = {16'h0, ptr_r};
            OFS_BEACON: rd_mux = {16'h0, beacon_r};
            OFS_SUPPLY: rd_mux = {30'h0, supply_off_r};
            default: hit = 1'b0;
        endcase
    end

    // Read data is taken in the setup cycle so it stands in the access.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            prdata_r <= 32'h0000_0000;
        end else if (i_ce && i_psel && !i_penable) begin
            prdata_r <= rd_mux;
        end
    end

    // Writable settings.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cpu_run_r <= 1'b0;
            ee_addr_r <= '0;
            beacon_r <= BEACON_RST;
            supply_off_r <= SUPPLY_RST;
        end else if (wr_en) begin
            if (i_paddr == OFS_CTRL) begin
                cpu_run_r <= i_pwdata[CTL_CPU_RUN] && !soft_rst;
            end
            if (i_paddr == OFS_EE_ADDR) begin
                ee_addr_r <= i_pwdata[EE_AW-1:0];
            end
            if (i_paddr == OFS_BEACON) begin
                beacon_r <= i_pwdata[15:0];
            end
            if (i_paddr == OFS_SUPPLY) begin
                supply_off_r <= i_pwdata[1:0];
            end
        end
    end
    assign o_embedded_processor_run = cpu_run_r;

    // ****************************************************************
    // Configuration memory sequencer
    // ****************************************************************
    // A busy sequencer ignores new starts rather than queueing them.
    assign auto_go = cap_fire && strap_now.auto_ee_read;
    assign restart_go = wr_ctl && i_pwdata[CTL_EE_RESTART] &&
                        cpu_run_r && first_done_r;
    assign manual_go = wr_ctl && i_pwdata[CTL_EE_MANUAL] && second_done_r;
    assign o_ee_req = (st_r == SBC_ST_REQ);
    assign o_ee_addr = cur_addr_r;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_r <= SBC_ST_IDLE;
            burst_r <= 1'b0;
            word_r <= 8'h00;
            cur_addr_r <= '0;
        end else if (i_ce) begin
            unique case (st_r)
                SBC_ST_IDLE: begin
                    if (auto_go || restart_go) begin
                        st_r <= SBC_ST_REQ;
                        burst_r <= 1'b1;
                        word_r <= 8'h00;
                        cur_addr_r <= '0;
                    end else if (manual_go) begin
                        st_r <= SBC_ST_REQ;
                        burst_r <= 1'b0;
                        cur_addr_r <= ee_addr_r;
                    end
                end
                SBC_ST_REQ: begin
                    if (ack_s_r) begin
                        st_r <= SBC_ST_REL;
                    end
                end
                SBC_ST_REL: begin
                    if (!ack_s_r) begin
                        if (burst_r && word_r != BURST_LAST) begin
                            st_r <= SBC_ST_REQ;
                            word_r <= word_r + 8'h01;
                            cur_addr_r <= word_r + 8'h01;
                        end else begin
                            st_r <= SBC_ST_IDLE;
                            burst_r <= 1'b0;
                        end
                    end
                end
                default: st_r <= SBC_ST_IDLE;
            endcase
        end
    end

    // Boot progress; a soft reset starts the whole sequence over.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            first_done_r <= 1'b0;
            second_done_r <= 1'b0;
            boot_done_r <= 1'b0;
        end else if (i_ce) begin
            if (soft_rst) begin
                first_done_r <= 1'b0;
                second_done_r <= 1'b0;
                boot_done_r <= 1'b0;
            end else if (st_r == SBC_ST_REL && !ack_s_r) begin
                if (!burst_r) begin
                    boot_done_r <= 1'b1;
                end else if (word_r == BURST_LAST) begin
                    first_done_r <= 1'b1;
                    second_done_r <= first_done_r;
                end
            end
        end
    end

    // Word data taken on the acknowledge edge of each read.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ee_data_r <= '0;
            ptr_r <= '0;
        end else if (i_ce && st_r == SBC_ST_REQ && ack_s_r) begin
            ee_data_r <= dat_s_r;
            if (burst_r && word_r == PTR_WORD) begin
                ptr_r <= dat_s_r;
            end
        end
    end

    // ****************************************************************
    // Doze and supply control
    // ****************************************************************
    // Sleep ticks are rising edges of the slow clock seen through sync.
    assign slp_tick = slp_s_r && !slp_d_r;
    assign wake = doze_r && slp_tick && (slp_cnt_r == beacon_r - 16'h0001);

    // Wake wins over a doze request written in the same cycle.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            doze_r <= 1'b0;
            slp_cnt_r <= 16'h0000;
        end else if (i_ce) begin
            if (wake || soft_rst) begin
                doze_r <= 1'b0;
            end else if (wr_ctl && i_pwdata[CTL_DOZE]) begin
                doze_r <= 1'b1;
            end
            if (!doze_r || wake) begin
                slp_cnt_r <= 16'h0000;
            end else if (slp_tick) begin
                slp_cnt_r <= slp_cnt_r + 16'h0001;
            end
        end
    end

    // Core power always drops while dozing; the other two supplies drop only if marked unused.
    assign o_general_purpose_line_ten =
        !(doze_r && supply_off_r[SUP_SYNTH]);
    assign o_crystal_osc_enable_n =
        doze_r && supply_off_r[SUP_XOSC];
    assign o_core_power_en = !doze_r;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    a_strap_capture: assert property (
        i_ce && cap_fire |=> strap_r == $past(strap_now))
        else $error("straps not captured");
    a_strap_hold: assert property (
        cap_done && !cap_fire |=> $stable(strap_r))
        else $error("latched straps changed");
    a_no_flash_sel: assert property (
        strap_r.flash_cs == SBC_CS_NONE |-> o_flash_cs_en == 3'h0)
        else $error("flash select driven with no flash");
    a_auto_start: assert property (
        i_ce && cap_fire && strap_now.auto_ee_read && st_r == SBC_ST_IDLE
        |=> st_r == SBC_ST_REQ && burst_r)
        else $error("automatic read did not start");
    a_restart_cpu: assert property (
        $rose(burst_r) && first_done_r |-> $past(cpu_run_r))
        else $error("burst restart without running firmware");
    a_manual_gate: assert property (
        st_r == SBC_ST_REQ && !burst_r |-> second_done_r)
        else $error("manual read before second burst");
    a_ptr_load: assert property (
        i_ce && st_r == SBC_ST_REQ && ack_s_r && burst_r &&
        word_r == PTR_WORD |=> ptr_r == $past(dat_s_r))
        else $error("pointer word not stored");
    a_beacon_wake: assert property (
        i_ce && doze_r && slp_tick && slp_cnt_r == beacon_r - 16'h0001
        |=> !doze_r && o_core_power_en && o_general_purpose_line_ten &&
        !o_crystal_osc_enable_n ##1 !doze_r || $past(wr_ctl))
        else $error("no wake at beacon interval");
    a_doze_synth: assert property (
        doze_r && supply_off_r[SUP_SYNTH] |-> !o_general_purpose_line_ten)
        else $error("synthesizer supply left on in doze");

    c_auto_burst: cover property ($rose(first_done_r));
    c_second_burst: cover property ($rose(second_done_r));
    c_manual_read: cover property ($rose(boot_done_r));
    c_doze_wake: cover property (wake);

endmodule

/* File: sbc_ee_model.sv */
// Behavioural serial configuration memory on the loader's word port.
// Assumes the four-phase request and acknowledge of the loader on i_clk.
`timescale 1ns/1ns

module sbc_ee_model (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Word port and answer shaping.
    input wire logic i_req,
    input wire logic [7:0] i_addr,
    input wire logic [3:0] i_delay,
    input wire logic [7:0] i_salt,
    output logic o_ack,
    output logic [15:0] o_data
);
    logic [4:0] cnt_r;

    // ****************************************************************
    // Answer engine
    // ****************************************************************
    // Data is put out i_delay plus one edges before the acknowledge, so that it is
    // already stable when the loader's synchroniser sees the acknowledge.
    // Once released, the data lines show the inverse of the last word.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_r <= 5'h00;
            o_ack <= 1'b0;
            o_data <= 16'h0000;
        end else if (i_req && !o_ack) begin
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == 5'h00) begin
                o_data <= {i_salt, i_addr};
            end
            if (cnt_r > {1'b0, i_delay}) begin
                o_ack <= 1'b1;
            end
        end else if (!i_req && o_ack) begin
            cnt_r <= 5'h00;
            o_ack <= 1'b0;
            o_data <= ~o_data;
        end
    end
endmodule

/* File: sbc_strap_boot_loader_tb.sv */
// Self-checking bench for the strap and boot configuration loader.
// Assumes the memory model file and the design package are compiled first.
`timescale 1ns/1ns

`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
error_cnt++; $display("unexpected %s expected %0h seen %0h", nm, e, g); \
end end

module sbc_strap_boot_loader_tb;
    import sbc_pkg::*;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic cm = 1'b1;
    logic ce = 1'b1;
    logic sleep_clk = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] rd;
    logic err;
    logic [9:0] strap = 10'h217;
    logic [3:0] dly = 4'h0;
    logic [7:0] salt = 8'h5A;
    logic [31:0] prdata;
    logic pready, pslverr, ee_req, ee_ack, lten, oscn, core_en, run;
    logic [7:0] ee_addr;
    logic [15:0] ee_data;
    sbc_strap_t cfg;
    logic [2:0] cs_en;
    int error_cnt = 0;
    int n_compared = 0;
    int n_wait = 0;
    logic [9:0] pat [4] = '{10'h217, 10'h0A8, 10'h352, 10'h1EC};

    // The sleep oscillator is an external crystal and runs free.
    always #10 i_clk = ~i_clk;
    always #15625 sleep_clk = ~sleep_clk;

    sbc_strap_boot_loader DUT (.i_clk(i_clk), .i_arst_n(i_arst_n),
        .i_ce(ce), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_strap_data_bus(strap),
        .i_card_mode_select(cm), .o_ee_req(ee_req), .o_ee_addr(ee_addr),
        .i_ee_ack(ee_ack), .i_ee_data(ee_data), .i_sleep_clk(sleep_clk),
        .o_general_purpose_line_ten(lten), .o_crystal_osc_enable_n(oscn),
        .o_core_power_en(core_en), .o_cfg(cfg), .o_flash_cs_en(cs_en),
        .o_embedded_processor_run(run));

    sbc_ee_model MEM (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_req(ee_req),
        .i_addr(ee_addr), .i_delay(dly), .i_salt(salt), .o_ack(ee_ack),
        .o_data(ee_data));

    // ****************************************************************
    // Bus and checking tasks
    // ****************************************************************
    task report_and_stop;
        $display("mismatches %0d compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // One APB transfer; read data and error are taken at the ready edge.
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge i_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge i_clk);
        penable <= 1'b1;
        for (int k = 0; k <= 20; k++) begin
            @(posedge i_clk);
            if (pready === 1'b1) begin
                break;
            end
            if (k == 20) begin
                error_cnt++;
                $display("unexpected pready expected 1 seen 0");
                report_and_stop();
            end
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(nm, e, rd)
    endtask

    // Polls one STATUS flag under a bound.
    task wait_bit(input int b);
        for (int k = 0; k < 200; k++) begin
            apb(1'b0, OFS_STATUS, 32'h0000_0000);
            if (rd[b] === 1'b1) begin
                return;
            end
        end
        error_cnt++;
        $display("unexpected status flag expected 1 seen 0");
        report_and_stop();
    endtask

    task settle;
        @(negedge i_clk);
    endtask

    // Compares every latched field against the pins that were present.
    task chk_straps(input logic [9:0] p, input logic c);
        settle();
        `CHK("flash_16bit", p[9], cfg.flash_16bit)
        `CHK("flash_cs", p[8:7], cfg.flash_cs)
        `CHK("cs_en", (&p[8:7]) ? 3'h0 : 3'h1 << p[8:7], cs_en)
        `CHK("host_mode", p[6:5], cfg.host_mode)
        `CHK("pad_pci", p[4], cfg.pad_pci)
        `CHK("big_endian", p[3], cfg.big_endian)
        `CHK("fw_from_flash", p[2], cfg.fw_from_flash)
        `CHK("auto_ee_read", p[0], cfg.auto_ee_read)
        `CHK("card_mode", c, cfg.card_mode)
        rchk(OFS_STRAP, {22'h0, p[9:2], p[0], c}, "straps");
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (12) @(posedge i_clk);
        i_arst_n <= 1'b1;
        repeat (6) @(posedge i_clk);
        chk_straps(pat[0], 1'b1);
        rchk(OFS_BEACON, 32'h0000_0064, "beacon reset");
        rchk(OFS_SUPPLY, 32'h0000_0003, "supply reset");
        rchk(8'h40, 32'h0000_0000, "unmapped data");
        `CHK("pslverr", 1'b1, err)
        strap <= ~pat[0];
        apb(1'b1, OFS_STRAP, 32'h0000_0000);
        wait_bit(3);
        rchk(OFS_EE_PTR, 32'h0000_5A03, "burst pointer");
        rchk(OFS_EE_DATA, 32'h0000_5A07, "burst last");
        chk_straps(pat[0], 1'b1);
        for (int i = 1; i < 4; i++) begin
            strap <= pat[i];
            cm <= i[0];
            apb(1'b1, OFS_CTRL, 32'h0000_0001);
            repeat (6) @(posedge i_clk);
            chk_straps(pat[i], i[0]);
            `CHK("auto req off", 1'b0, ee_req)
        end
        // A restart without a running processor must be ignored.
        apb(1'b1, OFS_CTRL, 32'h0000_0004);
        repeat (20) @(posedge i_clk);
        `CHK("refused restart", 1'b0, ee_req)
        rchk(OFS_STATUS, 32'h0000_0000, "refused status");
        // Flash boot: soft reset, automatic burst, then run; slower memory answers.
        strap <= pat[0];
        cm <= 1'b0;
        dly <= 4'h6;
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        wait_bit(3);
        salt <= 8'hC3;
        apb(1'b1, OFS_CTRL, 32'h0000_0002);
        settle();
        `CHK("cpu run", 1'b1, run)
        apb(1'b1, OFS_CTRL, 32'h0000_0006);
        wait_bit(4);
        rchk(OFS_EE_PTR, 32'h0000_C303, "second pointer");
        apb(1'b1, OFS_EE_ADDR, 32'h0000_002C);
        apb(1'b1, OFS_CTRL, 32'h0000_000A);
        wait_bit(5);
        rchk(OFS_EE_DATA, 32'h0000_C32C, "manual word");
        // Doze with one and then the other supply switched off.
        for (int k = 1; k < 3; k++) begin
            apb(1'b1, OFS_BEACON, 32'h0000_0002);
            apb(1'b1, OFS_SUPPLY, k);
            apb(1'b1, OFS_CTRL, 32'h0000_0012);
            settle();
            `CHK("core in doze", 1'b0, core_en)
            `CHK("line ten doze", ~k[0], lten)
            `CHK("osc_n doze", k[1], oscn)
            // Two rising slow clock edges take at least 1562 fast cycles, just over 1500.
            n_wait = 0;
            while (n_wait <= 6000 && core_en !== 1'b1) begin
                @(posedge i_clk);
                n_wait++;
            end
            if (core_en !== 1'b1) begin
                error_cnt++;
                $display("unexpected wake expected 1 seen 0");
                report_and_stop();
            end
            `CHK("doze length", 1'b1, n_wait > 1500)
            settle();
            `CHK("core woken", 1'b1, core_en)
            `CHK("line ten awake", 1'b1, lten)
            `CHK("osc_n awake", 1'b0, oscn)
            rchk(OFS_CTRL, 32'h0000_0002, "ctrl after wake");
        end
        // A frozen block must not take a write.
        ce <= 1'b0;
        apb(1'b1, OFS_BEACON, 32'h0000_0055);
        ce <= 1'b1;
        rchk(OFS_BEACON, 32'h0000_0002, "frozen write");
        report_and_stop();
    end
endmodule
